//--- core/ddc_ctrl_params.svh
`ifndef DDC_CTRL_PARAMS_SVH
`define DDC_CTRL_PARAMS_SVH
`define OVR_THR_I_ADDR 12'h0211
`define OVR_THR_Q_ADDR 12'h0212
`define OVERRANGE_OUTPUT_CONFIG_ADDR 12'h0213
`define PRESET_MODE_ADDR 12'h0214
`define PRESET_SEL_ADDR 12'h0215
`define IRQ_STATUS_ADDR 12'h0220
`define IRQ_MASK_ADDR 12'h0221
`define FREQ_A_BASE_ADDR 12'h0230
`define PHASE_A_BASE_ADDR 12'h0234
`define FREQ_B_BASE_ADDR 12'h0238
`define PHASE_B_BASE_ADDR 12'h023c
`define OVR_THR_I_RESET 8'hf2
`define OVR_THR_Q_RESET 8'hab
`define OVERRANGE_OUTPUT_CONFIG_RESET 8'h07
`define OVERRANGE_PIN_ENABLE_BIT 3
`define OVR_HOLD_BASE 8
`endif

//--- core/ddc_ctrl_pkg.sv
package ddc_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_REGISTER,
    MODE_PINS_EACH,
    MODE_PINS_A_BOTH,
    MODE_RESERVED
  } preset_mode_t;
endpackage : ddc_ctrl_pkg

//--- core/preset_store.sv
// Four presets per converter; read data registered
module preset_store #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [4];
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        mem[wr_idx] <= wr_data;
      rd_data <= mem[rd_idx];
    end
  end
endmodule : preset_store

//--- core/overrange_stretch.sv
`include "ddc_ctrl_params.svh"

// Stretches one flag to at least 8 * 2^exp cycles
module overrange_stretch (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic detect,
  input wire logic [2:0] hold_exp,
  output logic stretched
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (detect)
      cnt_nxt = 11'(`OVR_HOLD_BASE << hold_exp);
    else if (cnt_r != 11'h000)
      cnt_nxt = cnt_r - 11'h001;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cnt_r <= 11'h000;
    else if (clk_en)
      cnt_r <= cnt_nxt;
  end
  assign stretched = cnt_r != 11'h000;
endmodule : overrange_stretch

//--- core/ddc_ovr_nco_ctrl.sv
`include "ddc_ctrl_params.svh"

module ddc_ovr_nco_ctrl
  import ddc_ctrl_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int FREQ_W = 32,
  parameter int PHASE_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic single_channel,
  input wire logic [SAMPLE_W-1:0] chan_a_abs_i,
  input wire logic [SAMPLE_W-1:0] chan_a_abs_q,
  input wire logic [SAMPLE_W-1:0] chan_b_abs_i,
  input wire logic [SAMPLE_W-1:0] chan_b_abs_q,
  input wire logic [1:0] preset_pins_a,
  input wire logic [1:0] preset_pins_b,
  output logic chan_a_flag_out0,
  output logic chan_a_flag_out1,
  output logic chan_b_flag_out0,
  output logic chan_b_flag_out1,
  output logic link_ovr_a_i,
  output logic link_ovr_a_q,
  output logic link_ovr_b_i,
  output logic link_ovr_b_q,
  output logic [1:0] active_preset_a,
  output logic [1:0] active_preset_b,
  output logic [FREQ_W-1:0] freq_word_a,
  output logic [PHASE_W-1:0] phase_word_a,
  output logic [FREQ_W-1:0] freq_word_b,
  output logic [PHASE_W-1:0] phase_word_b,
  output logic irq
);
  typedef struct packed {
    logic [7:0] thr_i;
    logic [7:0] thr_q;
    logic [7:0] overrange_output_config;
    logic [1:0] mode;
    logic [3:0] sel;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] det_prev;
    logic [3:0] flags;
    logic [3:0] link_flags;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic irq;
    logic [1:0] pins_a_s1;
    logic [1:0] pins_a_s2;
    logic [1:0] pins_b_s1;
    logic [1:0] pins_b_s2;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [3:0] det;
  logic [3:0] stretched;
  logic [2:0] hold_exp;
  logic [FREQ_W-1:0] fa_q;
  logic [FREQ_W-1:0] fb_q;
  logic [PHASE_W-1:0] pa_q;
  logic [PHASE_W-1:0] pb_q;

  // Absolute level compared against 8-bit threshold scaled to sample MSBs
  function automatic logic over_thr(input logic [SAMPLE_W-1:0] lvl, input logic [7:0] thr);
    over_thr = lvl[SAMPLE_W-1 -: 8] >= thr;
  endfunction : over_thr

  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    in_bank = a[11:2] == base[11:2];
  endfunction : in_bank

  assign hold_exp = st_r.overrange_output_config[2:0];
  assign det[0] = over_thr(chan_a_abs_i, st_r.thr_i);
  assign det[1] = over_thr(chan_a_abs_q, st_r.thr_q);
  assign det[2] = over_thr(chan_b_abs_i, st_r.thr_i);
  assign det[3] = over_thr(chan_b_abs_q, st_r.thr_q);

  for (genvar g = 0; g < 4; g++)
  begin : g_str
    overrange_stretch u_str (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .detect(det[g]),
      .hold_exp(hold_exp),
      .stretched(stretched[g])
    );
  end

  preset_store #(.WIDTH(FREQ_W)) u_freq_a (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(reg_wr && in_bank(reg_addr, `FREQ_A_BASE_ADDR)),
    .wr_idx(reg_addr[1:0]),
    .wr_data(reg_wdata[FREQ_W-1:0]),
    .rd_idx(st_r.act_a),
    .rd_data(fa_q)
  );
  preset_store #(.WIDTH(PHASE_W)) u_phase_a (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(reg_wr && in_bank(reg_addr, `PHASE_A_BASE_ADDR)),
    .wr_idx(reg_addr[1:0]),
    .wr_data(reg_wdata[PHASE_W-1:0]),
    .rd_idx(st_r.act_a),
    .rd_data(pa_q)
  );
  preset_store #(.WIDTH(FREQ_W)) u_freq_b (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(reg_wr && in_bank(reg_addr, `FREQ_B_BASE_ADDR)),
    .wr_idx(reg_addr[1:0]),
    .wr_data(reg_wdata[FREQ_W-1:0]),
    .rd_idx(st_r.act_b),
    .rd_data(fb_q)
  );
  preset_store #(.WIDTH(PHASE_W)) u_phase_b (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(reg_wr && in_bank(reg_addr, `PHASE_B_BASE_ADDR)),
    .wr_idx(reg_addr[1:0]),
    .wr_data(reg_wdata[PHASE_W-1:0]),
    .rd_idx(st_r.act_b),
    .rd_data(pb_q)
  );

  always_comb
  begin
    st_nxt = st_r;
    // Preset pins come from board logic: two-stage synchronisers
    st_nxt.pins_a_s1 = preset_pins_a;
    st_nxt.pins_a_s2 = st_r.pins_a_s1;
    st_nxt.pins_b_s1 = preset_pins_b;
    st_nxt.pins_b_s2 = st_r.pins_b_s1;
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `OVR_THR_I_ADDR: st_nxt.thr_i = reg_wdata[7:0];
        `OVR_THR_Q_ADDR: st_nxt.thr_q = reg_wdata[7:0];
        `OVERRANGE_OUTPUT_CONFIG_ADDR: st_nxt.overrange_output_config = {4'h0, reg_wdata[3:0]};
        `PRESET_MODE_ADDR: st_nxt.mode = reg_wdata[1:0];
        `PRESET_SEL_ADDR: st_nxt.sel = reg_wdata[3:0];
        `IRQ_STATUS_ADDR: st_nxt.irq_status = st_r.irq_status & ~reg_wdata[3:0];
        `IRQ_MASK_ADDR: st_nxt.irq_mask = reg_wdata[3:0];
        default: ;
      endcase
    end
    // Rising detections set sticky status; set wins over clear
    st_nxt.irq_status = st_nxt.irq_status | (det & ~st_r.det_prev);
    st_nxt.det_prev = det;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
    // Pins follow stretched detections only when enabled
    if (st_r.overrange_output_config[`OVERRANGE_PIN_ENABLE_BIT])
      st_nxt.flags = stretched;
    else
      st_nxt.flags = 4'h0;
    st_nxt.link_flags = stretched;
    // Active preset selection
    unique case (preset_mode_t'(st_r.mode))
      MODE_REGISTER:
      begin
        st_nxt.act_a = st_r.sel[1:0];
        st_nxt.act_b = st_r.sel[3:2];
      end
      MODE_PINS_EACH:
      begin
        st_nxt.act_a = st_r.pins_a_s2;
        st_nxt.act_b = st_r.pins_b_s2;
      end
      MODE_PINS_A_BOTH:
      begin
        st_nxt.act_a = st_r.pins_a_s2;
        st_nxt.act_b = st_r.pins_a_s2;
      end
      MODE_RESERVED:
      begin
        st_nxt.act_a = st_r.act_a;
        st_nxt.act_b = st_r.act_b;
      end
    endcase
    // Single channel: converter A method only, B mirrors A
    if (single_channel)
      st_nxt.act_b = st_nxt.act_a;
    // Register reads: data stand only in the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `OVR_THR_I_ADDR: st_nxt.rdata = {24'h00_0000, st_r.thr_i};
        `OVR_THR_Q_ADDR: st_nxt.rdata = {24'h00_0000, st_r.thr_q};
        `OVERRANGE_OUTPUT_CONFIG_ADDR: st_nxt.rdata = {24'h00_0000, st_r.overrange_output_config};
        `PRESET_MODE_ADDR: st_nxt.rdata = {30'h0000_0000, st_r.mode};
        `PRESET_SEL_ADDR: st_nxt.rdata = {28'h000_0000, st_r.sel};
        `IRQ_STATUS_ADDR: st_nxt.rdata = {28'h000_0000, st_r.irq_status};
        `IRQ_MASK_ADDR: st_nxt.rdata = {28'h000_0000, st_r.irq_mask};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.thr_i <= `OVR_THR_I_RESET;
      st_r.thr_q <= `OVR_THR_Q_RESET;
      st_r.overrange_output_config <= `OVERRANGE_OUTPUT_CONFIG_RESET;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign chan_a_flag_out0 = st_r.flags[0];
  assign chan_a_flag_out1 = st_r.flags[1];
  assign chan_b_flag_out0 = st_r.flags[2];
  assign chan_b_flag_out1 = st_r.flags[3];
  assign link_ovr_a_i = st_r.link_flags[0];
  assign link_ovr_a_q = st_r.link_flags[1];
  assign link_ovr_b_i = st_r.link_flags[2];
  assign link_ovr_b_q = st_r.link_flags[3];
  assign active_preset_a = st_r.act_a;
  assign active_preset_b = st_r.act_b;
  assign freq_word_a = fa_q;
  assign phase_word_a = pa_q;
  assign freq_word_b = fb_q;
  assign phase_word_b = pb_q;
  assign irq = st_r.irq;
endmodule : ddc_ovr_nco_ctrl

//--- tb/ddc_ctrl_assertions.sv
module ddc_ctrl_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic single_channel,
  input wire logic [1:0] preset_pins_a,
  input wire logic [1:0] preset_pins_b,
  input wire logic chan_a_flag_out0,
  input wire logic chan_a_flag_out1,
  input wire logic link_ovr_a_i,
  input wire logic [1:0] active_preset_a,
  input wire logic [1:0] active_preset_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_r;
  logic [1:0] mode_r;
  logic [3:0] sel_r;
  // Shadow of the pin enable, preset mode and preset select fields
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      en_r <= 1'b0;
      mode_r <= 2'h0;
      sel_r <= 4'h0;
    end
    else if (reg_wr && clk_en)
    begin
      if (reg_addr == 12'h0213)
        en_r <= reg_wdata[3];
      if (reg_addr == 12'h0214)
        mode_r <= reg_wdata[1:0];
      if (reg_addr == 12'h0215)
        sel_r <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_pins_off:
  assert property (!en_r && !$past(en_r) |-> !chan_a_flag_out0 && !chan_a_flag_out1)
    else $error("flag pin high while disabled");
  a_pin_min:
  assert property ($rose(chan_a_flag_out0) |-> chan_a_flag_out0 [*8])
    else $error("flag pulse too short");
  a_link_min:
  assert property ($rose(link_ovr_a_i) |-> link_ovr_a_i [*8])
    else $error("link pulse too short");
  a_mode0_sel:
  assert property ($past(mode_r) == 2'h0 |-> active_preset_a == $past(sel_r[1:0])
    && ($past(single_channel) || active_preset_b == $past(sel_r[3:2])))
    else $error("preset differs from select");
  a_single_b:
  assert property ($past(single_channel) && $past(mode_r) != 2'h3
    |-> active_preset_b == active_preset_a) else $error("single b not a");
  a_mode1_pins:
  assert property ($past(mode_r) == 2'h1 |-> active_preset_a == $past(preset_pins_a, 3)
    && ($past(single_channel) || active_preset_b == $past(preset_pins_b, 3)))
    else $error("preset differs from pins");
  a_mode2_pins:
  assert property ($past(mode_r) == 2'h2 |-> active_preset_a == $past(preset_pins_a, 3)
    && active_preset_b == active_preset_a) else $error("preset differs from a pins");
  a_rd_mode:
  assert property (reg_rd && reg_addr == 12'h0214
    |=> reg_rdata == {30'h0000_0000, $past(mode_r)}) else $error("mode read wrong");
endmodule : ddc_ctrl_assertions

bind ddc_ovr_nco_ctrl ddc_ctrl_assertions i_chk (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .single_channel, .preset_pins_a, .preset_pins_b,
  .chan_a_flag_out0, .chan_a_flag_out1, .link_ovr_a_i, .active_preset_a, .active_preset_b);

//--- tb/board_model.sv
module board_model (
  input wire logic sys_clk,
  input wire logic [3:0] want,
  input wire logic flag,
  output logic [3:0] pins,
  output int pulse_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial pins = 4'h0;
  // Pins move just after an edge; pulse width in cycles
  always @(posedge sys_clk)
  begin
    pins <= want;
    cnt <= flag ? cnt + 1 : 0;
    if (!flag && cnt != 0)
      pulse_len <= cnt;
  end
endmodule : board_model

//--- tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_ctrl_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, single_channel = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] reg_addr = 12'h000, lvl = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, fa, fb, fr [8];
  logic [15:0] pa, pb, ph [8];
  logic [3:0] want = 4'h0, flags, pins;
  logic [1:0] act_a, act_b;
  logic [3:0] links;
  logic irq;
  int pulse_len, error_cnt = 0, n_tests = 0;

  always #2.5 sys_clk = ~sys_clk;

  ddc_ovr_nco_ctrl i_dut (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .single_channel, .chan_a_abs_i(lvl), .chan_a_abs_q(lvl),
    .chan_b_abs_i(lvl), .chan_b_abs_q(lvl), .preset_pins_a(pins[1:0]),
    .preset_pins_b(pins[3:2]), .chan_a_flag_out0(flags[0]), .chan_a_flag_out1(flags[1]),
    .chan_b_flag_out0(flags[2]), .chan_b_flag_out1(flags[3]), .link_ovr_a_i(links[0]),
    .link_ovr_a_q(links[1]), .link_ovr_b_i(links[2]), .link_ovr_b_q(links[3]),
    .active_preset_a(act_a),
    .active_preset_b(act_b), .freq_word_a(fa), .phase_word_a(pa), .freq_word_b(fb),
    .phase_word_b(pb), .irq);
  board_model i_board (.sys_clk, .want, .flag(flags[0]), .pins, .pulse_len);

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
    chk(reg_rdata, e);
  endtask : rd

  task automatic det();
    lvl <= 12'hf20;
    cyc(1);
    lvl <= 12'h000;
  endtask : det

  // Register mode and pin modes both carry A in v[1:0]
  function automatic logic [3:0] exp_idx(input logic [1:0] m, input logic [3:0] v);
    logic [1:0] b;
    b = (m == MODE_PINS_A_BOTH) ? v[1:0] : v[3:2];
    return {single_channel ? v[1:0] : b, v[1:0]};
  endfunction : exp_idx

  task automatic chk_preset(input logic [1:0] m, input logic [3:0] v);
    logic [3:0] e;
    e = exp_idx(m, v);
    cyc(7);
    chk({act_b, act_a}, e);
    chk({pa, fa}, {ph[{1'b0, e[1:0]}], fr[{1'b0, e[1:0]}]});
    chk({pb, fb}, {ph[{1'b1, e[3:2]}], fr[{1'b1, e[3:2]}]});
  endtask : chk_preset

  task automatic finish_test();
    $display("checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  initial
  begin
    logic [1:0] m;
    logic [3:0] v;
    int g;
    void'($urandom(32'h9029_2316));
    cyc(5);
    reset <= 1'b0;
    rd(12'h0211, 32'h0000_00f2);
    rd(12'h0213, 32'h0000_0007);
    rd(12'h0215, 32'h0000_0000);
    rd(12'h02ff, 32'h0000_0000);
    wr(12'h0214, 32'h0000_00fe);
    rd(12'h0214, 32'h0000_0002);
    wr(12'h0215, 32'h0000_00ff);
    rd(12'h0215, 32'h0000_000f);
    for (int i = 0; i < 8; i++)
    begin
      fr[i] = $urandom();
      ph[i] = 16'($urandom());
      wr(12'h0230 + 12'(i + (i & 4)), fr[i]);
      wr(12'h0234 + 12'(i + (i & 4)), {16'h0000, ph[i]});
    end
    for (int i = 0; i < 24; i++)
    begin
      m = 2'(i % 3);
      v = 4'($urandom());
      single_channel <= i[3];
      want <= v;
      wr(12'h0214, {30'h0000_0000, m});
      if (m == MODE_REGISTER)
        wr(12'h0215, {28'h000_0000, v});
      chk_preset(m, v);
    end
    det();
    cyc(3);
    chk(flags, 4'h0);
    chk(links, 4'hf);
    cyc(1100);
    for (int e = 0; e < 3; e++)
    begin
      g = $urandom_range(6, 2);
      wr(12'h0213, 32'h0000_0008 + e);
      det();
      cyc(g - 1);
      det();
      cyc(2);
      chk(flags, 4'hf);
      cyc(g + (8 << e) + 4);
      chk(pulse_len, g + (8 << e));
    end
    wr(12'h0220, 32'h0000_000f);
    wr(12'h0211, 32'h0000_00f3);
    wr(12'h0221, 32'h0000_0002);
    det();
    cyc(3);
    rd(12'h0220, 32'h0000_000a);
    chk(irq, 1'b1);
    wr(12'h0221, 32'h0000_0001);
    cyc(1);
    chk(irq, 1'b0);
    wr(12'h0221, 32'h0000_0008);
    cyc(1);
    chk(irq, 1'b1);
    wr(12'h0220, 32'h0000_0008);
    cyc(1);
    chk(irq, 1'b0);
    // Frozen clock enable: the mask write must not land
    clk_en <= 1'b0;
    wr(12'h0221, 32'h0000_0002);
    cyc(2);
    clk_en <= 1'b1;
    cyc(2);
    chk(irq, 1'b0);
    wr(12'h0221, 32'h0000_0002);
    cyc(1);
    chk(irq, 1'b1);
    finish_test();
  end
endmodule : testbench
